/* rotiu_pkg.sv */
package rotiu_pkg;

    // operations carried out by the unit
    typedef enum logic {
        ROTIU_ROTATE_LEFT_NO_CARRY_OP,
        ROTIU_ROTATE_RIGHT_THROUGH_CARRY_OP
    } rotiu_op_e;

    // operand encoding bits
    localparam logic DEST_WORKING = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic ACCESS_BANK_SEL = 1'b0;
    localparam logic ACCESS_BSR_SEL = 1'b1;

    // addressing
    localparam int ADDR_W = 12;
    localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

    // register port map (byte addresses)
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;
    localparam logic [7:0] REG_BANK_SELECT_OFS = 8'h04;
    localparam logic [7:0] REG_STATUS_OFS = 8'h08;
    localparam logic [7:0] REG_WORKING_OFS = 8'h0C;

    // field positions
    localparam int CTRL_EXT_EN_BIT = 0;
    localparam int STATUS_C_BIT = 0;
    localparam int STATUS_Z_BIT = 1;
    localparam int STATUS_N_BIT = 2;
    localparam int STATUS_BUSY_BIT = 3;

    // reset values
    localparam logic CTRL_EXT_EN_RST = 1'b0;
    localparam logic [3:0] BANK_SELECT_RST = 4'h0;
    localparam logic [7:0] WORKING_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;

endpackage : rotiu_pkg

/* rotiu_top.sv */
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - left rotate, bit 7 wraps into bit 0
// - right rotate through carry, bit 0 to carry
// - dest 0 writes working register only
// - dest 1 writes result back to operand
// - access bit 0 uses access bank
// - access bit 1 uses bank select register
// - extended set, access bit 0, low address uses indexed offset
module rotiu_top
    import rotiu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // instruction decoder request
    input wire logic op_valid,
    output logic op_ready,
    input wire rotiu_op_e op_sel,
    input wire logic [7:0] op_file,
    input wire logic op_dest,
    input wire logic op_access,
    output logic op_done,
    // index pointer for indexed literal offset mode
    input wire logic [ADDR_W-1:0] index_ptr,
    // data memory port, read data one cycle after mem_rd
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // state seen by the core
    output logic [7:0] working_out,
    output logic carry_out,
    output logic zero_out,
    output logic negative_out
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_READ,
        ST_PROCESS,
        ST_WRITE
    } rotiu_state_e;

    rotiu_state_e state_r;
    rotiu_state_e state_nxt;
    rotiu_op_e op_r;
    logic dest_r;
    logic access_r;
    logic [7:0] file_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [7:0] status_word;
    logic [7:0] result_r;
    logic [7:0] result_nxt;
    logic carry_res_r;
    logic carry_res_nxt;
    logic ext_en_r;
    logic [3:0] bank_select_register_r;
    logic [7:0] working_r;
    logic carry_r;
    logic zero_r;
    logic negative_r;
    logic mem_rd_r;
    logic mem_wr_r;
    logic [7:0] mem_wdata_r;
    logic op_done_r;
    logic [7:0] reg_rdata_r;
    logic wr_ctrl;
    logic wr_bank;
    logic wr_status;
    logic wr_working;
    logic writeback;

    // phase sequencer: decode, read, process, write
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (op_valid) begin
                    state_nxt = ST_DECODE;
                end
            end
            ST_DECODE: state_nxt = ST_READ;
            ST_READ: state_nxt = ST_PROCESS;
            ST_PROCESS: state_nxt = ST_WRITE;
            ST_WRITE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign op_ready = (state_r == ST_IDLE);

    // capture the instruction fields on acceptance
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            op_r <= ROTIU_ROTATE_LEFT_NO_CARRY_OP;
            dest_r <= DEST_FILE;
            access_r <= ACCESS_BSR_SEL;
            file_r <= 8'h00;
        end else if (op_valid && op_ready) begin
            op_r <= op_sel;
            dest_r <= op_dest;
            access_r <= op_access;
            file_r <= op_file;
        end
    end

    // operand address resolution during decode
    always_comb begin
        if (access_r == ACCESS_BSR_SEL) begin
            addr_nxt = {bank_select_register_r, file_r};
        end else if (ext_en_r && (file_r <= ACCESS_LOW_LIMIT)) begin
            // offset wraps within the data space
            addr_nxt = index_ptr + {4'h0, file_r};
        end else if (file_r <= ACCESS_LOW_LIMIT) begin
            addr_nxt = {ACCESS_LOW_BANK, file_r};
        end else begin
            addr_nxt = {ACCESS_HIGH_BANK, file_r};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            addr_r <= '0;
        end else if (state_r == ST_DECODE) begin
            addr_r <= addr_nxt;
        end
    end

    // memory read strobe in the read phase, data lands in process
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_rd_r <= 1'b0;
        end else begin
            mem_rd_r <= (state_nxt == ST_READ);
        end
    end

    // write data captured once, so they stay put after the write phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_wdata_r <= 8'h00;
        end else if (state_r == ST_PROCESS) begin
            mem_wdata_r <= result_nxt;
        end
    end

    // rotate datapath
    always_comb begin
        if (op_r == ROTIU_ROTATE_LEFT_NO_CARRY_OP) begin
            result_nxt = {mem_rdata[6:0], mem_rdata[7]};
            carry_res_nxt = carry_r;
        end else begin
            result_nxt = {carry_r, mem_rdata[7:1]};
            carry_res_nxt = mem_rdata[0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            result_r <= 8'h00;
            carry_res_r <= FLAG_RST;
        end else if (state_r == ST_PROCESS) begin
            result_r <= result_nxt;
            carry_res_r <= carry_res_nxt;
        end
    end

    // write phase strobes
    assign writeback = (state_r == ST_WRITE);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_wr_r <= 1'b0;
        end else begin
            mem_wr_r <= (state_nxt == ST_WRITE) && (dest_r == DEST_FILE);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            op_done_r <= 1'b0;
        end else begin
            op_done_r <= (state_nxt == ST_WRITE);
        end
    end

    // register port decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_bank = 1'b0;
        wr_status = 1'b0;
        wr_working = 1'b0;
        if (reg_wr && reg_addr == REG_CTRL_OFS) begin
            wr_ctrl = 1'b1;
        end else if (reg_wr && reg_addr == REG_BANK_SELECT_OFS) begin
            wr_bank = 1'b1;
        end else if (reg_wr && reg_addr == REG_STATUS_OFS) begin
            wr_status = 1'b1;
        end else if (reg_wr && reg_addr == REG_WORKING_OFS) begin
            wr_working = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_en_r <= CTRL_EXT_EN_RST;
        end else if (wr_ctrl) begin
            ext_en_r <= reg_wdata[CTRL_EXT_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bank_select_register_r <= BANK_SELECT_RST;
        end else if (wr_bank) begin
            bank_select_register_r <= reg_wdata[3:0];
        end
    end

    // working register; the rotate result wins over a software write
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            working_r <= WORKING_RST;
        end else if (writeback && dest_r == DEST_WORKING) begin
            working_r <= result_r;
        end else if (wr_working) begin
            working_r <= reg_wdata;
        end
    end

    // flags; hardware update wins over a software write
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            carry_r <= FLAG_RST;
            zero_r <= FLAG_RST;
            negative_r <= FLAG_RST;
        end else if (writeback) begin
            carry_r <= carry_res_r;
            zero_r <= (result_r == 8'h00);
            negative_r <= result_r[7];
        end else if (wr_status) begin
            carry_r <= reg_wdata[STATUS_C_BIT];
            zero_r <= reg_wdata[STATUS_Z_BIT];
            negative_r <= reg_wdata[STATUS_N_BIT];
        end
    end

    // status word from the named field positions
    always_comb begin
        status_word = 8'h00;
        status_word[STATUS_C_BIT] = carry_r;
        status_word[STATUS_Z_BIT] = zero_r;
        status_word[STATUS_N_BIT] = negative_r;
        status_word[STATUS_BUSY_BIT] = !op_ready;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_r <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_addr == REG_CTRL_OFS) begin
            reg_rdata_r <= {7'h00, ext_en_r};
        end else if (reg_addr == REG_BANK_SELECT_OFS) begin
            reg_rdata_r <= {4'h0, bank_select_register_r};
        end else if (reg_addr == REG_STATUS_OFS) begin
            reg_rdata_r <= status_word;
        end else if (reg_addr == REG_WORKING_OFS) begin
            reg_rdata_r <= working_r;
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

    assign mem_addr = addr_r;
    assign mem_rd = mem_rd_r;
    assign mem_wr = mem_wr_r;
    assign mem_wdata = mem_wdata_r;
    assign op_done = op_done_r;
    assign reg_rdata = reg_rdata_r;
    assign working_out = working_r;
    assign carry_out = carry_r;
    assign zero_out = zero_r;
    assign negative_out = negative_r;

endmodule : rotiu_top

`default_nettype wire

/* rotiu_top_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module rotiu_top_chk
    import rotiu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // request and memory side
    input wire logic op_valid,
    input wire logic op_ready,
    input wire rotiu_op_e op_sel,
    input wire logic [7:0] op_file,
    input wire logic op_dest,
    input wire logic op_access,
    input wire logic op_done,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    // core state
    input wire logic [7:0] working_out,
    input wire logic carry_out,
    input wire logic zero_out,
    input wire logic negative_out
);
    logic take;
    logic [7:0] rd_q;
    logic c0_q;
    assign take = op_valid && op_ready;
    // operand as the write phase sees it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 8'h00;
            c0_q <= 1'b0;
        end else begin
            rd_q <= mem_rdata;
            c0_q <= rd_q[0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    op_phase_a: assert property (take |-> ##2 mem_rd ##2 op_done)
        else $error("op phases out of step");
    ready_gap_a: assert property (take |=> !op_ready [*4] ##1 op_ready)
        else $error("ready not held off for the op");
    wb_on_a: assert property (take && op_dest |-> ##4 mem_wr)
        else $error("missing write back");
    wb_off_a: assert property (take && !op_dest |-> ##4 !mem_wr)
        else $error("write back with dest 0");
    w_keep_a: assert property (take && op_dest |=> $stable(working_out) [*5])
        else $error("working changed with dest 1");
    rot_left_a: assert property (take && op_sel == ROTIU_ROTATE_LEFT_NO_CARRY_OP
        && op_dest |-> ##4 mem_wdata == {rd_q[6:0], rd_q[7]})
        else $error("left rotate result wrong");
    rot_right_a: assert property (take && op_sel ==
        ROTIU_ROTATE_RIGHT_THROUGH_CARRY_OP && op_dest |->
        ##4 mem_wdata == {carry_out, rd_q[7:1]} ##1 carry_out == c0_q)
        else $error("right rotate result wrong");
    nz_flags_a: assert property (op_done && mem_wr |=>
        zero_out == ($past(mem_wdata) == 8'h00) &&
        negative_out == ($past(mem_wdata) > 8'h7F))
        else $error("flags do not follow result");
    bank_addr_a: assert property (take && op_access
        |-> ##2 mem_addr[7:0] == $past(op_file, 2))
        else $error("banked address wrong");
    acc_addr_a: assert property (take && !op_access && op_file >
        ACCESS_LOW_LIMIT |-> ##2 mem_addr == {ACCESS_HIGH_BANK, $past(op_file, 2)})
        else $error("access bank address wrong");
    cover property (take && op_sel == ROTIU_ROTATE_RIGHT_THROUGH_CARRY_OP);
    cover property (take && !op_access && op_file <= ACCESS_LOW_LIMIT);
    cover property (op_done && !mem_wr);
endmodule // rotiu_top_chk
`default_nettype wire

/* test_rotiu_top.sv */
`timescale 1ns/1ns
`default_nettype none
module test_rotiu_top
    import rotiu_pkg::*;
;
    logic sys_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, op_dest = 1'b0;
    logic op_access = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    rotiu_op_e op_sel = ROTIU_ROTATE_LEFT_NO_CARRY_OP;
    logic [7:0] op_file = 8'h00, mem_rdata = 8'h00;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [ADDR_W-1:0] index_ptr = 12'h000;
    logic op_ready, op_done, mem_rd, mem_wr, carry_out, zero_out, negative_out;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata, reg_rdata, working_out;
    int err_count = 0, cmp_count = 0;
    localparam rotiu_op_e L = ROTIU_ROTATE_LEFT_NO_CARRY_OP;
    localparam rotiu_op_e R = ROTIU_ROTATE_RIGHT_THROUGH_CARRY_OP;

    always #10 sys_clk = ~sys_clk;

    rotiu_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .op_valid(op_valid),
        .op_ready(op_ready), .op_sel(op_sel), .op_file(op_file),
        .op_dest(op_dest), .op_access(op_access), .op_done(op_done),
        .index_ptr(index_ptr), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .working_out(working_out),
        .carry_out(carry_out), .zero_out(zero_out),
        .negative_out(negative_out));

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // data only in the cycle after the strobe
    task automatic reg_r(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        chk(reg_rdata, e);
    endtask

    task automatic op(input rotiu_op_e s, input logic [7:0] f, input logic d,
            input logic a, input logic [7:0] v, input logic [11:0] ea,
            input logic [7:0] er);
        int n;
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_sel <= s;
        op_file <= f;
        op_dest <= d;
        op_access <= a;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        for (n = 0; n < 8 && mem_rd !== 1'b1; n++) @(posedge sys_clk);
        if (mem_rd !== 1'b1) begin
            err_count++;
            test_done();
        end
        chk(mem_addr, ea);
        mem_rdata <= v;
        @(posedge sys_clk);
        // inverted so a late sample cannot pass by luck
        mem_rdata <= ~v;
        for (n = 0; n < 8 && op_done !== 1'b1; n++) @(posedge sys_clk);
        if (op_done !== 1'b1) begin
            err_count++;
            test_done();
        end
        chk(mem_wr, d);
        if (d) chk(mem_wdata, er);
        else begin
            @(posedge sys_clk);
            chk(working_out, er);
        end
    endtask

    task automatic t_reset();
        reg_r(REG_CTRL_OFS, 8'h00);
        reg_r(REG_STATUS_OFS, 8'h00);
        reg_r(REG_WORKING_OFS, 8'h00);
        reg_r(8'h10, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_left();
        reg_w(REG_BANK_SELECT_OFS, 8'h03);
        op(L, 8'h20, 1'b1, 1'b1, 8'hA5, 12'h320, 8'h4B);
        reg_r(REG_WORKING_OFS, 8'h00);
        reg_r(REG_STATUS_OFS, 8'h00);
        $display("test left done");
    endtask

    task automatic t_right();
        reg_w(REG_STATUS_OFS, 8'h01);
        op(R, 8'h80, 1'b0, 1'b0, 8'hE6, 12'hF80, 8'hF3);
        reg_r(REG_STATUS_OFS, 8'h04);
        op(R, 8'h30, 1'b1, 1'b1, 8'h01, 12'h330, 8'h00);
        reg_r(REG_STATUS_OFS, 8'h03);
        op(L, 8'h40, 1'b1, 1'b0, 8'h80, 12'h040, 8'h01);
        reg_r(REG_STATUS_OFS, 8'h01);
        $display("test right done");
    endtask

    task automatic t_index();
        reg_w(REG_CTRL_OFS, 8'h01);
        index_ptr <= 12'h100;
        op(L, 8'h5F, 1'b0, 1'b0, 8'h81, 12'h15F, 8'h03);
        op(L, 8'h60, 1'b0, 1'b0, 8'h02, 12'hF60, 8'h04);
        op(L, 8'h5F, 1'b0, 1'b1, 8'h10, 12'h35F, 8'h20);
        reg_w(REG_CTRL_OFS, 8'h00);
        op(L, 8'h10, 1'b0, 1'b0, 8'h7F, 12'h010, 8'hFE);
        $display("test index done");
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_left();
        t_right();
        t_index();
        test_done();
    end
endmodule // test_rotiu_top

bind rotiu_top rotiu_top_chk i_chk (.*);
`default_nettype wire
